// File: design/gpmd_pkg.sv
package gpmd_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] GPMD_PORT_PIN_DATA_OFF = 12'h000;
  localparam logic [11:0] GPMD_DATA_ALIAS_LAST = 12'h3fc;
  localparam logic [11:0] GPMD_PIN_DIRECTION_CONTROL_OFF = 12'h400;
  localparam logic [11:0] GPMD_PERIPH_IDENT_BYTE2_OFF = 12'hfe8;
  localparam logic [11:0] GPMD_PERIPH_IDENT_BYTE3_OFF = 12'hfec;
  localparam logic [11:0] GPMD_CELL_IDENT_BYTE0_OFF = 12'hff0;
  localparam logic [11:0] GPMD_CELL_IDENT_BYTE1_OFF = 12'hff4;
  localparam logic [11:0] GPMD_CELL_IDENT_BYTE2_OFF = 12'hff8;
  localparam logic [11:0] GPMD_CELL_IDENT_BYTE3_OFF = 12'hffc;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int GPMD_MASK_LSB = 2;
  localparam int GPMD_MASK_MSB = 9;
  localparam int GPMD_DATA_MSB = 7;
  localparam logic [7:0] GPMD_DATA_RESET = 8'h00;
  localparam logic [7:0] GPMD_DIR_RESET = 8'h00;

  // ****************************************
  // Pin synchroniser depth
  // ****************************************
  localparam int GPMD_SYNC_STAGES = 3;

  // ****************************************
  // Identification bytes (arbitrary values)
  // ****************************************
  localparam logic [7:0] GPMD_ID_PERIPH2 = 8'h3a;
  localparam logic [7:0] GPMD_ID_PERIPH3 = 8'h07;
  localparam logic [7:0] GPMD_ID_CELL0 = 8'h21;
  localparam logic [7:0] GPMD_ID_CELL1 = 8'h42;
  localparam logic [7:0] GPMD_ID_CELL2 = 8'h63;
  localparam logic [7:0] GPMD_ID_CELL3 = 8'h84;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gpmd_apb_req_t;

  typedef struct packed {
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
  } gpmd_pad_drive_t;

  typedef enum logic [0:0] {
    GPMD_ST_IDLE = 1'b0,
    GPMD_ST_ACCESS = 1'b1
  } gpmd_state_t;

endpackage

// File: design/gpmd_pin_sync.sv
`timescale 1ns/1ns
module gpmd_pin_sync
  import gpmd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Raw pins and settled level
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level_out
);

  // ****************************************
  // Three stages; a change counts once the last two agree
  // ****************************************
  logic [WIDTH-1:0] stage_ff [GPMD_SYNC_STAGES];
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_stage [GPMD_SYNC_STAGES];
  logic [WIDTH-1:0] nxt_level;

  always_comb begin
    nxt_stage[0] = pins_in;
    for (int i = 1; i < GPMD_SYNC_STAGES; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
    nxt_level = level_ff;
    for (int b = 0; b < WIDTH; b++) begin
      if (stage_ff[1][b] == stage_ff[2][b]) begin
        nxt_level[b] = stage_ff[2][b];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < GPMD_SYNC_STAGES; i++) begin
        stage_ff[i] <= '0;
      end
      level_ff <= '0;
    end else begin
      for (int i = 0; i < GPMD_SYNC_STAGES; i++) begin
        stage_ff[i] <= nxt_stage[i];
      end
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule

// File: design/gpmd_port.sv
`timescale 1ns/1ns
// Behaviour
// - A written data bit reaches its pin only when that pin is an output; input-pin bits stay.
// - A data write updates only bits whose mask bit, address bits [9:2], is high.
// - A data read returns masked-off bits as zero.
// - An unmasked read bit is the last written value for outputs, the pin level for inputs.
// - The data field clears to zero on reset.
// - Data sits in bits 7:0; bits 31:8 read zero and software preserves them.
// - The data register decodes at 256 word locations, each with its own mask.
// - Peripheral ident registers at 0xfe8 and 0xfec return fixed bytes.
// - Four cell ident registers at 0xff0 to 0xffc return fixed bytes; writes do nothing.
// - A direction bit of 1 makes the pin an output, 0 an input; it resets to all inputs.
module gpmd_port
  import gpmd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Port pins
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_out
);

  // ****************************************
  // State
  // ****************************************
  gpmd_apb_req_t req;
  gpmd_pad_drive_t drive;
  gpmd_state_t state_ff, nxt_state;
  logic [WIDTH-1:0] data_ff, nxt_data;
  logic [WIDTH-1:0] dir_ff, nxt_dir;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic [WIDTH-1:0] pin_level;

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};

  gpmd_pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in(pad_in),
    .level_out(pin_level)
  );

  // The mask lives in the address so that two drivers never need a read-modify-write.
  function automatic logic [WIDTH-1:0] addr_mask(input logic [11:0] a);
    addr_mask = a[GPMD_MASK_MSB:GPMD_MASK_LSB];
  endfunction

  function automatic logic is_data(input logic [11:0] a);
    is_data = (a <= GPMD_DATA_ALIAS_LAST) && (a[1:0] == 2'b00);
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_data = data_ff;
    nxt_dir = dir_ff;
    nxt_rdata = rdata_ff;
    nxt_ready = 1'b0;
    nxt_err = 1'b0;
    case (state_ff)
      GPMD_ST_IDLE: begin
        if (req.psel && !req.penable) begin
          nxt_state = GPMD_ST_ACCESS;
          nxt_ready = 1'b1;
          nxt_rdata = 32'h0000_0000;
          if (is_data(req.paddr)) begin
            if (req.pwrite) begin
              for (int b = 0; b < WIDTH; b++) begin
                if (addr_mask(req.paddr)[b] && dir_ff[b]) begin
                  nxt_data[b] = req.pwdata[b];
                end
              end
            end else begin
              for (int b = 0; b < WIDTH; b++) begin
                if (addr_mask(req.paddr)[b]) begin
                  nxt_rdata[b] = dir_ff[b] ? data_ff[b] : pin_level[b];
                end
              end
            end
          end else begin
            case (req.paddr)
              GPMD_PIN_DIRECTION_CONTROL_OFF: begin
                if (req.pwrite) begin
                  nxt_dir = req.pwdata[GPMD_DATA_MSB:0];
                end else begin
                  nxt_rdata[GPMD_DATA_MSB:0] = dir_ff;
                end
              end
              GPMD_PERIPH_IDENT_BYTE2_OFF: nxt_rdata[7:0] = GPMD_ID_PERIPH2;
              GPMD_PERIPH_IDENT_BYTE3_OFF: nxt_rdata[7:0] = GPMD_ID_PERIPH3;
              GPMD_CELL_IDENT_BYTE0_OFF: nxt_rdata[7:0] = GPMD_ID_CELL0;
              GPMD_CELL_IDENT_BYTE1_OFF: nxt_rdata[7:0] = GPMD_ID_CELL1;
              GPMD_CELL_IDENT_BYTE2_OFF: nxt_rdata[7:0] = GPMD_ID_CELL2;
              GPMD_CELL_IDENT_BYTE3_OFF: nxt_rdata[7:0] = GPMD_ID_CELL3;
              default: nxt_err = 1'b1;
            endcase
          end
        end
      end
      GPMD_ST_ACCESS: begin
        nxt_state = GPMD_ST_IDLE;
      end
      default: nxt_state = GPMD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= GPMD_ST_IDLE;
      data_ff <= GPMD_DATA_RESET;
      dir_ff <= GPMD_DIR_RESET;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      data_ff <= nxt_data;
      dir_ff <= nxt_dir;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Pads take the register directly; data held for an input pin is not driven out.
  assign drive = '{pad_out: data_ff, pad_oe: dir_ff};
  assign pad_out = drive.pad_out;
  assign pad_oe_out = drive.pad_oe;
  assign prdata_out = rdata_ff;
  assign pready_out = ready_ff;
  assign pslverr_out = err_ff;

  // ****************************************
  // Checks
  // ****************************************
  input_bits_kept_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!dir_ff[0] && !$past(rst_in)) |=> ($stable(data_ff[0]) || $past(dir_ff[0])))
    else $error("Data bit of an input pin changed.");

  masked_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in && pwrite_in && is_data(paddr_in))
    |=> ((data_ff ^ $past(data_ff)) & ~$past(addr_mask(paddr_in) & dir_ff)) == '0)
    else $error("Masked-off data bit changed on write.");

  masked_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in && !pwrite_in && is_data(paddr_in))
    |=> (prdata_out[WIDTH-1:0] & ~$past(addr_mask(paddr_in))) == '0)
    else $error("Masked-off read bit not zero.");

  read_source_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in && !pwrite_in && is_data(paddr_in) && paddr_in[9:2] == 8'hff)
    |=> prdata_out[WIDTH-1:0] == $past((dir_ff & data_ff) | (~dir_ff & pin_level)))
    else $error("Read value source wrong.");

  reset_clear_a: assert property (@(posedge clk_in)
    rst_in |=> (data_ff == '0 && dir_ff == '0 && pad_oe_out == '0))
    else $error("Data or direction not cleared by reset.");

  reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    pready_out |-> prdata_out[31:8] == 24'h000000)
    else $error("Reserved bits not zero.");

  ident_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in && !pwrite_in && paddr_in == GPMD_CELL_IDENT_BYTE3_OFF)
    |=> prdata_out == {24'h000000, GPMD_ID_CELL3})
    else $error("Cell ident byte wrong.");

  one_cycle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in) |=> pready_out ##1 !pready_out)
    else $error("Access did not complete in one wait-free cycle.");

  pins_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    pad_oe_out == dir_ff && pad_out == data_ff)
    else $error("Pads do not follow registers.");

endmodule

// File: dv/gpmd_pin_model.sv
`timescale 1ns/1ns
module gpmd_pin_model (
  // Port pins seen from the board
  input wire logic [7:0] pad_out_in,
  input wire logic [7:0] pad_oe_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pad_in_out
);
  // ****************************************
  // Pin levels
  // ****************************************
  // Driven pins read back their own level; undriven pins follow the board source.
  assign pad_in_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_in);
endmodule

// File: dv/gpio_masked_data_register_tb.sv
`timescale 1ns/1ns
module gpio_masked_data_register_tb
  import gpmd_pkg::*;
;
  // ****************************************
  // Signals and reference state
  // ****************************************
  logic clk_in;
  logic rst_in;
  gpmd_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pad_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_out;
  logic [7:0] ext;
  logic [7:0] data_m;
  logic [7:0] dir_m;
  logic [31:0] rd;
  logic [31:0] wv;
  logic er;
  int err_count;
  int n_compared;
  logic [11:0] ido [6] = '{12'hfe8, 12'hfec, 12'hff0, 12'hff4, 12'hff8, 12'hffc};
  logic [7:0] idv [6];

  gpmd_port i_gpmd_port (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .psel_in(req.psel),
    .penable_in(req.penable),
    .pwrite_in(req.pwrite),
    .paddr_in(req.paddr),
    .pwdata_in(req.pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe_out(pad_oe_out)
  );

  gpmd_pin_model i_gpmd_pin_model (
    .pad_out_in(pad_out),
    .pad_oe_in(pad_oe_out),
    .ext_in(ext),
    .pad_in_out(pad_in)
  );

  always #2 clk_in = ~clk_in;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The wait on pready is bounded so that a silent slave cannot hang the bus.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    req <= '0;
    if (n >= 20) err_count++;
  endtask

  function automatic logic [7:0] rd_exp(input logic [11:0] a);
    return a[9:2] & ((dir_m & data_m) | (~dir_m & ext));
  endfunction

  task automatic dwr(input logic [11:0] a, input logic [7:0] wd);
    apb(1'b1, a, {24'($urandom), wd});
    data_m = (data_m & ~(a[9:2] & dir_m)) | (wd & a[9:2] & dir_m);
  endtask

  task automatic drd(input logic [11:0] a);
    repeat (6) @(posedge clk_in);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, rd_exp(a)});
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #60000;
    err_count++;
    complete_run();
  end

  initial begin
    idv = '{GPMD_ID_PERIPH2, GPMD_ID_PERIPH3, GPMD_ID_CELL0, GPMD_ID_CELL1,
      GPMD_ID_CELL2, GPMD_ID_CELL3};
    clk_in = 1'b0;
    rst_in = 1'b1;
    req = '0;
    ext = 8'h5a;
    data_m = 8'h00;
    dir_m = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    void'($urandom(32'he206fc51));
    chk(pad_oe_out, 32'h0);
    apb(1'b0, 12'h400, 32'h0);
    chk(rd, 32'h0);
    drd(12'h3fc);
    chk(pad_out, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ido[i], 32'hff);
      apb(1'b0, ido[i], 32'h0);
      chk(rd, {24'h0, idv[i]});
    end
    apb(1'b1, 12'h404, 32'hff);
    chk(er, 1'b1);
    apb(1'b1, 12'h400, 32'hff);
    dir_m = 8'hff;
    dwr(12'h03c, 8'ha5);
    dwr(12'h3c0, 8'h3c);
    drd(12'h3fc);
    drd(12'h000);
    for (int k = 0; k < 150; k++) begin
      case ($urandom_range(3))
        0: begin
          wv = $urandom;
          apb(1'b1, 12'h400, wv);
          dir_m = wv[7:0];
        end
        1: ext <= 8'($urandom);
        2: dwr({2'b00, 8'($urandom), 2'b00}, 8'($urandom));
        default: drd({2'b00, 8'($urandom), 2'b00});
      endcase
      repeat (2) @(posedge clk_in);
      chk(pad_oe_out, dir_m);
      chk(pad_out & pad_oe_out, data_m & dir_m);
    end
    complete_run();
  end
endmodule
